// file: verilog/sadc_pkg.sv
// Constants, register map and state types of the SAR converter sequencer.
// Assumes one 25 MHz clock, APB register access and an external comparator.
//
// What this block does
// - Control register read/write at index F7H.
// - Bits 7-4 pick one of four inputs.
// - One input connected; next conversion uses new.
// - Bits 2-1 divide clock by 16, 8, 4.
// - Writing one to bit 0 starts conversion.
// - Approximation register starts at 200H.
// - Ten bits resolved MSB first, automatically.
// - Ten set-up clocks, four per bit, fifty.
// - Completion sets done flag, bit 3.
// - Upper eight bits high, lower two low.
// - Idle after result until next start.
// - New result always overwrites old result.
package sadc_pkg;

  // ==========================================================================
  // Register indices; the byte address is four times the index.
  // ==========================================================================
  localparam logic [9:0] IDX_CTRL = 10'h0f7;
  localparam logic [9:0] IDX_RES_HI = 10'h0f8;
  localparam logic [9:0] IDX_RES_LO = 10'h0f9;
  localparam logic [9:0] IDX_IRQ_STAT = 10'h0fa;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h0fb;

  // ==========================================================================
  // Control register fields and reset values.
  // ==========================================================================
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_DIV_LSB = 1;
  localparam int CTRL_EOC_BIT = 3;
  localparam int CTRL_CHAN_LSB = 4;
  localparam logic [3:0] CHAN_RESET = 4'h0;
  localparam logic [1:0] DIV_RESET = 2'h0;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

  // Interrupt status bits.
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_BAD_CHAN_BIT = 1;

  // ==========================================================================
  // Divider codes and the divide ratios they select.
  // ==========================================================================
  localparam logic [1:0] DIV_CODE_16 = 2'h0;
  localparam logic [1:0] DIV_CODE_8 = 2'h1;
  localparam logic [1:0] DIV_CODE_4 = 2'h2;
  localparam logic [4:0] DIV_RATIO_16 = 5'h10;
  localparam logic [4:0] DIV_RATIO_8 = 5'h08;
  localparam logic [4:0] DIV_RATIO_4 = 5'h04;

  // ==========================================================================
  // Conversion timing in conversion clocks.
  // ==========================================================================
  localparam int NUM_BITS = 10;
  localparam logic [3:0] SETUP_CLKS = 4'ha;
  localparam logic [3:0] BIT_CLKS = 4'h4;
  localparam logic [5:0] CONV_CLKS = 6'h32;
  localparam logic [9:0] SAR_MID = 10'h200;
  localparam logic [3:0] MSB_IDX = 4'h9;

  typedef enum logic [1:0] {SADC_IDLE, SADC_SETUP, SADC_BITS} sadc_state_t;

endpackage

// file: verilog/sadc_tick_if.sv
// Link between the sequencer and its conversion clock divider.
// Assumes both ends share the reference clock.
`timescale 1ns/1ps
`default_nettype none
interface sadc_tick_if;
  logic run;
  logic [1:0] div_code;
  logic tick;
  modport ctl (output run, output div_code, input tick);
  modport gen (input run, input div_code, output tick);
endinterface
`default_nettype wire

// file: verilog/sadc_divider.sv
// Conversion clock divider: one tick every 16, 8 or 4 reference cycles.
// Assumes run stays high for the whole conversion and falls when idle.
`timescale 1ns/1ps
`default_nettype none
module sadc_divider (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  sadc_tick_if.gen tk
);
  typedef struct packed {
    logic [4:0] cnt;
  } sadc_div_regs_t;

  sadc_div_regs_t r_reg;
  sadc_div_regs_t r_next;
  logic [4:0] ratio;
  logic [4:0] gap_reg;

  always_comb begin
    unique case (tk.div_code)
      sadc_pkg::DIV_CODE_8: ratio = sadc_pkg::DIV_RATIO_8;
      sadc_pkg::DIV_CODE_4: ratio = sadc_pkg::DIV_RATIO_4;
      default: ratio = sadc_pkg::DIV_RATIO_16;
    endcase
  end

  // The count restarts whenever run is low, so every conversion begins on
  // a full conversion clock.
  always_comb begin
    r_next = r_reg;
    if (!tk.run || r_reg.cnt == ratio - 5'h01) begin
      r_next.cnt = 5'h00;
    end else begin
      r_next.cnt = r_reg.cnt + 5'h01;
    end
  end

  assign tk.tick = tk.run && (r_reg.cnt == ratio - 5'h01);

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Cycles seen since the last tick, for checking only.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !tk.run || tk.tick) begin
      gap_reg <= 5'h00;
    end else begin
      gap_reg <= gap_reg + 5'h01;
    end
  end

  chk_div_tick_gap: assert property (@(posedge i_ref_clk)
    disable iff (i_rst)
    tk.tick |-> gap_reg == ratio - 5'h01)
    else $error("conversion tick spacing differs from divide ratio");

endmodule
`default_nettype wire

// file: verilog/sadc_top.sv
// SAR converter sequencer with APB registers and a level interrupt.
// Assumes a synchronous comparator input that is high while the selected
// analog level is at or above the trial code on o_dac_code.
`timescale 1ns/1ps
`default_nettype none
module sadc_top #(
  parameter int ADDR_W = 12
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_comp_above,
  output logic [3:0] o_chan_sel,
  output logic [9:0] o_dac_code,
  output logic o_irq
);

  // ==========================================================================
  // Parameter check.
  // ==========================================================================
  if (ADDR_W < 10) begin : g_bad_addr_w
    $error("sadc_top: ADDR_W must be at least 10");
  end

  // ==========================================================================
  // State.
  // ==========================================================================
  typedef struct packed {
    logic [3:0] chan;
    logic [1:0] div;
    logic start;
    logic eoc;
    logic [7:0] res_hi;
    logic [1:0] res_lo;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    sadc_pkg::sadc_state_t st;
    logic [3:0] cnt;
    logic [3:0] bit_idx;
    logic [9:0] sar;
    logic [3:0] chan_sel;
    logic [1:0] act_div;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
  } sadc_regs_t;

  sadc_regs_t r_reg;
  sadc_regs_t r_next;

  sadc_tick_if tk ();

  sadc_divider u_div (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .tk(tk.gen)
  );

  assign tk.run = (r_reg.st != sadc_pkg::SADC_IDLE);
  assign tk.div_code = r_reg.act_div;

  // ==========================================================================
  // Address decode.
  // ==========================================================================
  logic [ADDR_W-1:0] a_ctrl;
  logic [ADDR_W-1:0] a_hi;
  logic [ADDR_W-1:0] a_lo;
  logic [ADDR_W-1:0] a_stat;
  logic [ADDR_W-1:0] a_mask;

  assign a_ctrl = ADDR_W'({sadc_pkg::IDX_CTRL, 2'h0});
  assign a_hi = ADDR_W'({sadc_pkg::IDX_RES_HI, 2'h0});
  assign a_lo = ADDR_W'({sadc_pkg::IDX_RES_LO, 2'h0});
  assign a_stat = ADDR_W'({sadc_pkg::IDX_IRQ_STAT, 2'h0});
  assign a_mask = ADDR_W'({sadc_pkg::IDX_IRQ_MASK, 2'h0});

  logic acc;
  logic wr_done;
  logic lane0;
  logic start_set;
  logic accept;
  logic [1:0] ev;
  logic [1:0] w1c;
  logic [9:0] sar_dec;

  // ==========================================================================
  // Next-state logic.
  // ==========================================================================
  always_comb begin
    r_next = r_reg;
    acc = i_psel && i_penable;
    // The access phase lasts two cycles so that read data comes from a
    // flip-flop; the write lands on the edge where pready is seen high.
    wr_done = acc && r_reg.pready && i_pwrite && !r_reg.pslverr;
    lane0 = i_pstrb[0];
    start_set = 1'b0;
    accept = 1'b0;
    ev = 2'h0;
    w1c = 2'h0;
    sar_dec = r_reg.sar;

    // Bus answer.
    r_next.pready = acc && !r_reg.pready;
    r_next.pslverr = 1'b0;
    r_next.prdata = 32'h0000_0000;
    if (acc && !r_reg.pready) begin
      if (i_paddr == a_ctrl) begin
        r_next.prdata[7:0] = {r_reg.chan, r_reg.eoc, r_reg.div,
                              r_reg.start};
      end else if (i_paddr == a_hi) begin
        r_next.prdata[7:0] = r_reg.res_hi;
      end else if (i_paddr == a_lo) begin
        r_next.prdata[1:0] = r_reg.res_lo;
      end else if (i_paddr == a_stat) begin
        r_next.prdata[1:0] = r_reg.irq_stat;
      end else if (i_paddr == a_mask) begin
        r_next.prdata[1:0] = r_reg.irq_mask;
      end else begin
        r_next.pslverr = 1'b1;
      end
    end

    // Register writes; the done flag and results are read-only.
    if (wr_done && lane0) begin
      if (i_paddr == a_ctrl) begin
        r_next.chan = i_pwdata[sadc_pkg::CTRL_CHAN_LSB +: 4];
        r_next.div = i_pwdata[sadc_pkg::CTRL_DIV_LSB +: 2];
        start_set = i_pwdata[sadc_pkg::CTRL_START_BIT];
      end else if (i_paddr == a_stat) begin
        w1c = i_pwdata[1:0];
      end else if (i_paddr == a_mask) begin
        r_next.irq_mask = i_pwdata[1:0];
      end
    end

    // Sequencer.
    unique case (r_reg.st)
      sadc_pkg::SADC_IDLE: begin
        // A start written mid-conversion waits here until the current
        // result is stored, so no request is lost.
        if (r_reg.start) begin
          accept = 1'b1;
          r_next.st = sadc_pkg::SADC_SETUP;
          r_next.cnt = 4'h0;
          r_next.sar = sadc_pkg::SAR_MID;
          r_next.bit_idx = sadc_pkg::MSB_IDX;
          r_next.eoc = 1'b0;
          r_next.act_div = r_reg.div;
          // Channel is latched so a mid-conversion write cannot swap it.
          unique case (r_reg.chan)
            4'h0: r_next.chan_sel = 4'h1;
            4'h1: r_next.chan_sel = 4'h2;
            4'h2: r_next.chan_sel = 4'h4;
            4'h3: r_next.chan_sel = 4'h8;
            default: begin
              r_next.chan_sel = 4'h0;
              ev[sadc_pkg::IRQ_BAD_CHAN_BIT] = 1'b1;
            end
          endcase
        end
      end
      sadc_pkg::SADC_SETUP: begin
        if (tk.tick) begin
          if (r_reg.cnt == sadc_pkg::SETUP_CLKS - 4'h1) begin
            r_next.st = sadc_pkg::SADC_BITS;
            r_next.cnt = 4'h0;
          end else begin
            r_next.cnt = r_reg.cnt + 4'h1;
          end
        end
      end
      sadc_pkg::SADC_BITS: begin
        if (tk.tick) begin
          if (r_reg.cnt == sadc_pkg::BIT_CLKS - 4'h1) begin
            r_next.cnt = 4'h0;
            if (!i_comp_above) begin
              sar_dec[r_reg.bit_idx] = 1'b0;
            end
            if (r_reg.bit_idx == 4'h0) begin
              r_next.sar = sar_dec;
              r_next.res_hi = sar_dec[9:2];
              r_next.res_lo = sar_dec[1:0];
              r_next.eoc = 1'b1;
              r_next.st = sadc_pkg::SADC_IDLE;
              r_next.chan_sel = 4'h0;
              ev[sadc_pkg::IRQ_DONE_BIT] = 1'b1;
            end else begin
              sar_dec[r_reg.bit_idx - 4'h1] = 1'b1;
              r_next.sar = sar_dec;
              r_next.bit_idx = r_reg.bit_idx - 4'h1;
            end
          end else begin
            r_next.cnt = r_reg.cnt + 4'h1;
          end
        end
      end
      default: begin
        r_next.st = sadc_pkg::SADC_IDLE;
      end
    endcase

    // Accepting consumes the pending start; a start written in the same
    // cycle stays pending for one more conversion.
    r_next.start = (r_reg.start && !accept) || start_set;

    // A new event wins over a write-one-to-clear in the same cycle.
    r_next.irq_stat = (r_reg.irq_stat & ~w1c) | ev;
    r_next.irq = |(r_next.irq_stat & r_next.irq_mask);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      r_reg <= '0;
      r_reg.chan <= sadc_pkg::CHAN_RESET;
      r_reg.div <= sadc_pkg::DIV_RESET;
      r_reg.irq_mask <= sadc_pkg::IRQ_MASK_RESET;
      r_reg.st <= sadc_pkg::SADC_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_prdata = r_reg.prdata;
  assign o_pready = r_reg.pready;
  assign o_pslverr = r_reg.pslverr;
  assign o_chan_sel = r_reg.chan_sel;
  assign o_dac_code = r_reg.sar;
  assign o_irq = r_reg.irq;

  // ==========================================================================
  // Checks.
  // ==========================================================================
  logic [5:0] ticks_seen;
  logic [9:0] low_mask;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst || accept) begin
      ticks_seen <= 6'h00;
    end else if (tk.tick) begin
      ticks_seen <= ticks_seen + 6'h01;
    end
  end

  assign low_mask = (10'h001 << r_reg.bit_idx) - 10'h001;

  chk_ctrl_write_back: assert property (@(posedge i_ref_clk)
    disable iff (i_rst)
    (acc && r_reg.pready && i_pwrite && i_pstrb[0] && !r_reg.pslverr
     && i_paddr == a_ctrl)
    |=> r_reg.chan == $past(i_pwdata[7:4])
        && r_reg.div == $past(i_pwdata[2:1]))
    else $error("control write did not land in channel and divider");

  chk_chan_single: assert property (@(posedge i_ref_clk)
    disable iff (i_rst)
    $onehot0(o_chan_sel)
    && (r_reg.st == sadc_pkg::SADC_IDLE -> o_chan_sel == 4'h0))
    else $error("more than one input connected");

  chk_chan_new_sel: assert property (@(posedge i_ref_clk)
    disable iff (i_rst)
    (accept && r_reg.chan < 4'h4)
    |=> o_chan_sel == (4'h1 << $past(r_reg.chan[1:0])))
    else $error("conversion did not use the selected input");

  chk_start_mid: assert property (@(posedge i_ref_clk)
    disable iff (i_rst)
    accept |=> o_dac_code == sadc_pkg::SAR_MID
               && r_reg.st == sadc_pkg::SADC_SETUP)
    else $error("conversion did not start at mid-scale");

  chk_sar_trial_bit: assert property (@(posedge i_ref_clk)
    disable iff (i_rst)
    r_reg.st == sadc_pkg::SADC_BITS
    |-> r_reg.sar[r_reg.bit_idx] && (r_reg.sar & low_mask) == 10'h000)
    else $error("trial bit or lower bits wrong during a bit step");

  chk_conv_fifty: assert property (@(posedge i_ref_clk)
    disable iff (i_rst)
    $rose(r_reg.eoc) |-> ticks_seen == sadc_pkg::CONV_CLKS)
    else $error("conversion did not last fifty conversion clocks");

  chk_done_sets_eoc: assert property (@(posedge i_ref_clk)
    disable iff (i_rst)
    ev[0] |=> r_reg.eoc && r_reg.irq_stat[0])
    else $error("completion did not set the done flag");

  chk_result_split: assert property (@(posedge i_ref_clk)
    disable iff (i_rst)
    ev[0] |=> {r_reg.res_hi, r_reg.res_lo} == $past(sar_dec))
    else $error("result not split into high and low registers");

  chk_idle_stays: assert property (@(posedge i_ref_clk)
    disable iff (i_rst)
    (r_reg.st == sadc_pkg::SADC_IDLE && !r_reg.start)
    |=> r_reg.st == sadc_pkg::SADC_IDLE)
    else $error("conversion began without a start");

  chk_eoc_low_busy: assert property (@(posedge i_ref_clk)
    disable iff (i_rst)
    r_reg.st != sadc_pkg::SADC_IDLE |-> !r_reg.eoc)
    else $error("done flag high during a conversion");

  chk_start_self_clr: assert property (@(posedge i_ref_clk)
    disable iff (i_rst)
    (accept && !start_set) |=> !r_reg.start)
    else $error("start bit did not clear on acceptance");

endmodule
`default_nettype wire

// file: test/sadc_comp_model.sv
// Behavioural comparator, input multiplexer and ladder for the sequencer.
// Assumes one-hot channel select and a trial code from the sequencer.
`timescale 1ns/1ps
`default_nettype none
module sadc_comp_model (
  input wire logic i_ref_clk,
  input wire logic [3:0] i_chan_sel,
  input wire logic [9:0] i_dac_code,
  input wire logic [39:0] i_levels,
  output logic o_above
);
  // ==========================================================================
  // Comparator
  // ==========================================================================
  // With no input connected the comparator sees a floating node, so the
  // model toggles every cycle rather than hold a tidy value.
  logic float_reg = 1'b0;

  always @(posedge i_ref_clk) begin
    float_reg <= ~float_reg;
  end

  always_comb begin
    case (i_chan_sel)
      4'h1: o_above = (i_levels[9:0] >= i_dac_code);
      4'h2: o_above = (i_levels[19:10] >= i_dac_code);
      4'h4: o_above = (i_levels[29:20] >= i_dac_code);
      4'h8: o_above = (i_levels[39:30] >= i_dac_code);
      default: o_above = float_reg;
    endcase
  end
endmodule
`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the converter sequencer over APB.
// Assumes the comparator model on the far side and a 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [3:0] chan;
    logic [1:0] div;
    logic [9:0] level;
    logic [4:0] d;
    logic [7:0] hi;
    logic [1:0] lo;
  } sadc_row_t;

  localparam logic [11:0] A_CTRL = {sadc_pkg::IDX_CTRL, 2'b00};
  localparam logic [11:0] A_HI = {sadc_pkg::IDX_RES_HI, 2'b00};
  localparam logic [11:0] A_LO = {sadc_pkg::IDX_RES_LO, 2'b00};
  localparam logic [11:0] A_STAT = {sadc_pkg::IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] A_MASK = {sadc_pkg::IDX_IRQ_MASK, 2'b00};

  logic clk, rst, psel, penable, pwrite, pready, pslverr, above, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, chan_sel;
  logic [9:0] dac_code;
  logic [39:0] lvl;
  logic err;
  int n_mismatch = 0;
  int n_tests = 0;
  int k, cyc;
  time tw;
  sadc_row_t r;
  sadc_row_t rows [4] = '{
    '{4'h0, 2'h0, 10'h3ff, 5'h10, 8'hff, 2'h3},
    '{4'h1, 2'h1, 10'h000, 5'h08, 8'h00, 2'h0},
    '{4'h2, 2'h2, 10'h155, 5'h04, 8'h55, 2'h1},
    '{4'h3, 2'h3, 10'h2aa, 5'h10, 8'haa, 2'h2}};

  sadc_top dut_u (.i_ref_clk(clk), .i_rst(rst), .i_paddr(paddr),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_comp_above(above),
    .o_chan_sel(chan_sel), .o_dac_code(dac_code), .o_irq(irq));

  sadc_comp_model comp_u (.i_ref_clk(clk), .i_chan_sel(chan_sel),
    .i_dac_code(dac_code), .i_levels(lvl), .o_above(above));

  always #20 clk = ~clk;

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // The slave's latency is not assumed; the wait ends on pready or at the bound of 50 cycles.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      $display("Error at %0t: no ready, got %h expected %h", $time, 0, 1);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    lvl = 40'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, A_CTRL, 32'h0); chk(rd, 32'h0);
    apb(1'b0, A_MASK, 32'h0); chk(rd, 32'h0);
    apb(1'b1, A_MASK, 32'h1);
    for (int i = 0; i < 4; i++) begin
      r = rows[i];
      lvl[r.chan * 10 +: 10] <= r.level;
      apb(1'b1, A_CTRL, {24'h0, r.chan, 4'h0});
      apb(1'b1, A_CTRL, {24'h0, r.chan, 1'b0, r.div, 1'b1});
      tw = $time;
      apb(1'b0, A_CTRL, 32'h0); chk(rd[3], 1'b0);
      chk(dac_code, sadc_pkg::SAR_MID);
      chk(chan_sel, 4'h1 << r.chan[1:0]);
      k = 0;
      while (irq !== 1'b1 && k < 2000) begin
        @(posedge clk);
        k++;
      end
      cyc = int'(($time - tw) / 40);
      chk(cyc >= 50 * r.d && cyc <= 50 * r.d + 6, 1'b1);
      apb(1'b0, A_CTRL, 32'h0);
      chk(rd, {24'h0, r.chan, 1'b1, r.div, 1'b0});
      apb(1'b0, A_HI, 32'h0); chk(rd, r.hi);
      apb(1'b0, A_LO, 32'h0); chk(rd, r.lo);
      apb(1'b1, A_STAT, 32'h1);
      apb(1'b0, A_STAT, 32'h0); chk(rd, 32'h0);
      chk(irq, 1'b0);
    end
    // A write to a read-only result is dropped without error.
    apb(1'b1, A_HI, 32'h55);
    apb(1'b0, A_HI, 32'h0); chk(rd, 32'haa);
    // A start without lane 0 enabled must not launch anything.
    pstrb <= 4'h0;
    apb(1'b1, A_CTRL, 32'h1);
    pstrb <= 4'hf;
    repeat (20) @(posedge clk);
    chk(chan_sel, 4'h0);
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd, 32'h3e);
    apb(1'b0, 12'h000, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    // Invalid code: nothing connected, flagged, masked from the output.
    apb(1'b1, A_MASK, 32'h0);
    apb(1'b1, A_CTRL, 32'h41);
    apb(1'b0, A_STAT, 32'h0); chk(rd[1], 1'b1);
    chk(chan_sel, 4'h0);
    repeat (820) @(posedge clk);
    apb(1'b0, A_STAT, 32'h0); chk(rd, 32'h3);
    chk(irq, 1'b0);
    apb(1'b1, A_STAT, 32'h3);
    apb(1'b0, A_STAT, 32'h0); chk(rd, 32'h0);
    // Reset in mid-conversion drops the run and restores the registers.
    apb(1'b1, A_MASK, 32'h1);
    apb(1'b1, A_CTRL, 32'h01);
    repeat (100) @(posedge clk);
    chk(chan_sel, 4'h1);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    chk(chan_sel, 4'h0);
    chk(dac_code, 32'h0);
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, A_MASK, 32'h0);
    chk(rd, 32'h0);
    chk(irq, 1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
